// [imf_consts.svh]
/*
 * constants for the missed-interrupt and bus-fault cause block:
 * register byte addresses, field masks, bit positions, reset values.
 * assumes it is included by its bare name wherever a number is needed.
 */
`ifndef IMF_CONSTS_SVH
`define IMF_CONSTS_SVH

// ============================================================
// register byte addresses
`define IMF_ADDR_MISS   32'h4000a820
`define IMF_ADDR_FAULT  32'he000ed3c
`define IMF_ADDR_ISTAT  32'h4000a824
`define IMF_ADDR_IMASK  32'h4000a828

// ============================================================
// implemented bits and reset values
`define IMF_MISS_MASK   32'h0000fffc
`define IMF_FAULT_MASK  32'h0000000f
`define IMF_IRQ_MASK    32'h00000003
`define IMF_RST_MISS    32'h00000000
`define IMF_RST_FAULT   32'h00000000
`define IMF_RST_IRQ     32'h00000000
`define IMF_ZERO_WORD   32'h00000000

// ============================================================
// fault cause bit positions
`define IMF_BIT_WRONG   3
`define IMF_BIT_PROT    2
`define IMF_BIT_UNMAP   1
`define IMF_BIT_OVF     0
`define IMF_FAULT_TOP   3

// ============================================================
// interrupt status bit positions
`define IMF_IRQ_MISS    0
`define IMF_IRQ_FAULT   1

// ============================================================
// access size and alignment codes
`define IMF_SIZE_WORD   2'h2
`define IMF_ALIGN_WORD  2'h0

`endif

// [imf_pkg.sv]
/*
 * types for the missed-interrupt and bus-fault cause block.
 * assumes imf_consts.svh carries every number.
 */
package imf_pkg;

	// ============================================================
	// axi response codes, in bus order
	typedef enum logic [1:0] {
		IMF_OKAY,
		IMF_EXOKAY,
		IMF_SLVERR
	} imf_resp_e;

	// ============================================================
	// one bus fault report from the fault detectors
	typedef struct packed {
		logic       valid;
		logic [1:0] size;
		logic [1:0] addrLow;
		logic       toApb;
		logic       isWrite;
		logic       isUser;
		logic       toGuarded;
		logic       beyondImpl;
	} imf_fault_s;

endpackage : imf_pkg

// [imf_top.sv]
/*
 * missed-interrupt flags and auxiliary bus-fault cause register,
 * reached over axi4-lite, with a sticky status and mask interrupt.
 * assumes event pulses, pending levels and fault reports come from
 * logic on clk_sys, so no synchroniser stands in front of them.
 */
// Operation
// RL1 - missed flags for external lines in bits 15..12, converter bit 11
// RL2 - missed flags for radio receive bit 10 and transmit bit 9
// RL3 - missed flag for radio timer in bit 8, software read and write
// RL4 - missed flags for serial two bit 6 and serial one bit 5
// RL5 - missed flag for sleep timer in bit 4
// RL6 - missed register resets to zero; bits 7,3,2 exist, rest read zero
// RL7 - wrong width cause bit 3 on byte or halfword peripheral access
// RL8 - wrong width cause also set by unaligned word access
// RL9 - protection cause bit 2 on user write to guarded target
// RL10 - unmapped cause bit 1 above last register in a peripheral block
// RL11 - unmapped cause also set above top of ram or flash
// RL12 - overflow cause bit 0 on fault while any cause already set
// RL13 - cause register resets to zero, bits 31..4 read zero
// RL14 - software pends a source elsewhere; writing zero changes nothing
// RL15 - missed flag set on new event while earlier request pending
// RL16 - set flags hold until software writes zero over them
`timescale 1ns/1ns
`include "imf_consts.svh"

module imf_top
	import imf_pkg::*;
#(
	parameter int SRC_COUNT = 16
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// axi4-lite write address
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// interrupt sources
	input  wire logic [SRC_COUNT-1:0] srcEvent,
	input  wire logic [SRC_COUNT-1:0] srcPending,
	// bus fault detectors
	input  wire imf_fault_s           busFault,
	// interrupt to the processor
	output logic                      irqOut
);

	// ============================================================
	// state
	logic              awHave;
	logic              wHave;
	logic [31:0]       awAddr;
	logic [31:0]       wData;
	logic [3:0]        wStrb;
	logic              awReady;
	logic              wReady;
	logic              bValid;
	imf_resp_e         bResp;
	logic              arReady;
	logic              rValid;
	logic [31:0]       rData;
	imf_resp_e         rResp;
	logic [31:0]       missFlags;
	logic [31:0]       faultCause;
	logic [31:0]       irqStatus;
	logic [31:0]       irqMask;
	logic              irqLine;

	// ============================================================
	// next values
	logic              next_awHave;
	logic              next_wHave;
	logic [31:0]       next_awAddr;
	logic [31:0]       next_wData;
	logic [3:0]        next_wStrb;
	logic              next_awReady;
	logic              next_wReady;
	logic              next_bValid;
	imf_resp_e         next_bResp;
	logic              next_arReady;
	logic              next_rValid;
	logic [31:0]       next_rData;
	imf_resp_e         next_rResp;
	logic [31:0]       next_missFlags;
	logic [31:0]       next_faultCause;
	logic [31:0]       next_irqStatus;
	logic [31:0]       next_irqMask;
	logic              next_irqLine;

	// ============================================================
	// event detection
	logic [31:0]       missSet;
	logic [31:0]       faultSet;
	logic              doWrite;
	logic [31:0]       strbBits;
	logic              anyMiss;

	// ============================================================
	// byte strobes to a bit mask
	function automatic logic [31:0] strobeMask(input logic [3:0] s);
		logic [31:0] m;
		m = `IMF_ZERO_WORD;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction : strobeMask

	// ============================================================
	// per-source missed detection
	// a literal cannot be bit-selected, so the mask gets a name
	localparam logic [31:0] MISS_BITS = `IMF_MISS_MASK;
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : gMiss
			if (gi < SRC_COUNT) begin : gSrc
				// a second event while still pending is lost
				assign missSet[gi] = srcEvent[gi] & srcPending[gi] &
					MISS_BITS[gi]; // RL15
			end else begin : gNone
				assign missSet[gi] = 1'b0;
			end
		end
	endgenerate

	assign anyMiss = |missSet;

	// ============================================================
	// fault cause classification
	always_comb begin
		faultSet = `IMF_ZERO_WORD;
		if (busFault.valid) begin
			faultSet[`IMF_BIT_WRONG] = busFault.toApb &
				(busFault.size != `IMF_SIZE_WORD); // RL7
			if (busFault.size == `IMF_SIZE_WORD &&
				busFault.addrLow != `IMF_ALIGN_WORD) begin
				faultSet[`IMF_BIT_WRONG] = 1'b1; // RL8
			end
			faultSet[`IMF_BIT_PROT] = busFault.isWrite &
				busFault.isUser & busFault.toGuarded; // RL9
			// detectors flag both peripheral holes and memory tops
			faultSet[`IMF_BIT_UNMAP] = busFault.beyondImpl; // RL10 RL11
			// judged on the value before this edge
			faultSet[`IMF_BIT_OVF] =
				|faultCause[`IMF_FAULT_TOP:0]; // RL12
		end
	end

	// ============================================================
	// write channel and register updates
	always_comb begin
		next_awHave     = awHave;
		next_wHave      = wHave;
		next_awAddr     = awAddr;
		next_wData      = wData;
		next_wStrb      = wStrb;
		next_bValid     = bValid;
		next_bResp      = bResp;
		next_missFlags  = missFlags;
		next_faultCause = faultCause;
		next_irqStatus  = irqStatus;
		next_irqMask    = irqMask;
		strbBits        = strobeMask(wStrb);
		doWrite         = awHave & wHave & ~bValid;

		if (s_axi_awvalid && awReady) begin
			next_awHave = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wReady) begin
			next_wHave = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end

		if (doWrite) begin
			next_awHave = 1'b0;
			next_wHave  = 1'b0;
			next_bValid = 1'b1;
			next_bResp  = IMF_OKAY;
			if (awAddr == `IMF_ADDR_MISS) begin
				// plain store: ones may be written, zeros clear
				next_missFlags = ((missFlags & ~strbBits) |
					(wData & strbBits)) & `IMF_MISS_MASK; // RL3 RL16
			end else if (awAddr == `IMF_ADDR_FAULT) begin
				next_faultCause = ((faultCause & ~strbBits) |
					(wData & strbBits)) & `IMF_FAULT_MASK; // RL16
			end else if (awAddr == `IMF_ADDR_ISTAT) begin
				next_irqStatus = irqStatus & ~(wData & strbBits);
			end else if (awAddr == `IMF_ADDR_IMASK) begin
				next_irqMask = ((irqMask & ~strbBits) |
					(wData & strbBits)) & `IMF_IRQ_MASK;
			end else begin
				next_bResp = IMF_SLVERR;
			end
		end

		// hardware set wins over a same-cycle software clear
		next_missFlags  = next_missFlags | missSet; // RL1 RL2 RL4 RL5 RL15
		next_faultCause = next_faultCause | faultSet; // RL7 RL8 RL9 RL10 RL11 RL12
		if (anyMiss) begin
			next_irqStatus[`IMF_IRQ_MISS] = 1'b1;
		end
		if (busFault.valid) begin
			next_irqStatus[`IMF_IRQ_FAULT] = 1'b1;
		end

		// one write at a time: hold off until the response is taken
		next_awReady = ~next_awHave & ~next_bValid;
		next_wReady  = ~next_wHave & ~next_bValid;
		next_irqLine = |(next_irqStatus & next_irqMask);
	end

	// ============================================================
	// read channel
	always_comb begin
		next_rValid = rValid;
		next_rData  = rData;
		next_rResp  = rResp;
		if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
		if (s_axi_arvalid && arReady) begin
			next_rValid = 1'b1;
			next_rResp  = IMF_OKAY;
			if (s_axi_araddr == `IMF_ADDR_MISS) begin
				next_rData = missFlags & `IMF_MISS_MASK; // RL6
			end else if (s_axi_araddr == `IMF_ADDR_FAULT) begin
				next_rData = faultCause & `IMF_FAULT_MASK; // RL13
			end else if (s_axi_araddr == `IMF_ADDR_ISTAT) begin
				next_rData = irqStatus & `IMF_IRQ_MASK;
			end else if (s_axi_araddr == `IMF_ADDR_IMASK) begin
				next_rData = irqMask & `IMF_IRQ_MASK;
			end else begin
				next_rData = `IMF_ZERO_WORD;
				next_rResp = IMF_SLVERR;
			end
		end
		next_arReady = ~next_rValid;
	end

	// ============================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			awHave     <= 1'b0;
			wHave      <= 1'b0;
			awAddr     <= `IMF_ZERO_WORD;
			wData      <= `IMF_ZERO_WORD;
			wStrb      <= 4'h0;
			awReady    <= 1'b0;
			wReady     <= 1'b0;
			bValid     <= 1'b0;
			bResp      <= IMF_OKAY;
			arReady    <= 1'b0;
			rValid     <= 1'b0;
			rData      <= `IMF_ZERO_WORD;
			rResp      <= IMF_OKAY;
			missFlags  <= `IMF_RST_MISS; // RL6
			faultCause <= `IMF_RST_FAULT; // RL13
			irqStatus  <= `IMF_RST_IRQ;
			irqMask    <= `IMF_RST_IRQ;
			irqLine    <= 1'b0;
		end else begin
			awHave     <= next_awHave;
			wHave      <= next_wHave;
			awAddr     <= next_awAddr;
			wData      <= next_wData;
			wStrb      <= next_wStrb;
			awReady    <= next_awReady;
			wReady     <= next_wReady;
			bValid     <= next_bValid;
			bResp      <= next_bResp;
			arReady    <= next_arReady;
			rValid     <= next_rValid;
			rData      <= next_rData;
			rResp      <= next_rResp;
			missFlags  <= next_missFlags;
			faultCause <= next_faultCause;
			irqStatus  <= next_irqStatus;
			irqMask    <= next_irqMask;
			irqLine    <= next_irqLine;
		end
	end

	// ============================================================
	// outputs, all straight from flip-flops
	assign s_axi_awready = awReady;
	assign s_axi_wready  = wReady;
	assign s_axi_bvalid  = bValid;
	assign s_axi_bresp   = bResp;
	assign s_axi_arready = arReady;
	assign s_axi_rvalid  = rValid;
	assign s_axi_rdata   = rData;
	assign s_axi_rresp   = rResp;
	assign irqOut        = irqLine;

endmodule : imf_top

// [imf_top_monitor.sv]
/* checker for imf_top: bus timing and read-back zero fields.
   assumes write address and data are offered together. */
`timescale 1ns/1ns
`include "imf_consts.svh"
// ====================
// checker
module imf_top_monitor (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp
);
	logic [31:0] rdAddr;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// read data is judged by the address it answers
	always_ff @(posedge clk_sys) begin
		if (rst) rdAddr <= 32'h0;
		else if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
	end
	sequence s_aw_take; s_axi_awvalid && s_axi_awready; endsequence
	sequence s_b_late; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
	a_write_answer: assert property (s_aw_take |=> s_b_late)
		else $error("write answer off time");
	a_write_release: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready) else $error("b not released");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && s_axi_arready) else $error("r not released");
	a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_reset_quiet: assert property ($fell(rst) |-> !s_axi_rvalid
		&& !s_axi_bvalid) else $error("answer after reset");
	a_miss_zeros: assert property (s_axi_rvalid && rdAddr ==
		`IMF_ADDR_MISS |-> (s_axi_rdata & ~`IMF_MISS_MASK) == 32'h0)
		else $error("missed flags unused bits set");
	a_cause_zeros: assert property (s_axi_rvalid && rdAddr ==
		`IMF_ADDR_FAULT |-> s_axi_rdata[31:4] == 28'h0)
		else $error("cause upper bits set");
	a_bad_addr: assert property (s_axi_rvalid && !(rdAddr inside
		{`IMF_ADDR_MISS, `IMF_ADDR_FAULT, `IMF_ADDR_ISTAT,
		`IMF_ADDR_IMASK}) |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
endmodule : imf_top_monitor

bind imf_top imf_top_monitor i_mon (.clk_sys, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp);

// [imf_src_model.sv]
/* interrupt sources with their pending latches.
   assumes fire and pendSet are one-cycle requests on clk_sys. */
`timescale 1ns/1ns
// ====================
// source model
module imf_src_model (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// requests from the bench
	input  wire logic [15:0] fire,
	input  wire logic [15:0] pendSet,
	// towards the block
	output logic      [15:0] srcEvent,
	output logic      [15:0] srcPending
);
	logic [15:0] next_srcEvent;
	logic [15:0] next_srcPending;
	always_comb begin
		next_srcEvent = fire;
		// zeros in pendSet leave the latch as it was
		next_srcPending = srcPending | srcEvent | pendSet;
	end
	always_ff @(posedge clk_sys) begin
		srcEvent <= rst ? 16'h0 : next_srcEvent;
		srcPending <= rst ? 16'h0 : next_srcPending;
	end
endmodule : imf_src_model

// [imf_tb_top.sv]
/* self-checking bench for imf_top over axi4-lite.
   assumes one clock; answers are checked in request order. */
`timescale 1ns/1ns
`include "imf_consts.svh"
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin errorCnt++; \
	$display("ERROR %0t mismatch %h %h", $time, a, b); end end
// ====================
// bench
module imf_tb_top
	import imf_pkg::*;
;
	logic        clk_sys = 1'h0, rst = 1'h1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, seed = 32'hf10e;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irqOut;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] srcEvent, srcPending, fire = 16'h0, pendSet = 16'h0;
	imf_fault_s  busFault = '0;
	logic [33:0] expQ[$], e;
	logic [9:0]  fTab[8] = '{10'h210, 10'h2b8, 10'h340, 10'h318,
		10'h30e, 10'h306, 10'h30a, 10'h301};
	logic [3:0]  fExp[8] = '{4'h8, 4'h8, 4'h8, 4'h0, 4'h4, 4'h0, 4'h0, 4'h2};
	int          errorCnt = 0, cmpCount = 0, cyc = 0;

	imf_top i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srcEvent,
		.srcPending, .busFault, .irqOut);
	imf_src_model i_src (.clk_sys, .rst, .fire, .pendSet, .srcEvent,
		.srcPending);

	initial begin
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs

	task automatic completeRun();
		$display("checks %0d errors %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : completeRun

	// address and data may be taken on different edges
	task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		expQ.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk_sys);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end while (!(aw && w));
		s_axi_bready <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [33:0] x);
		expQ.push_back(x);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask : rd

	// the extra edge lets the registered event reach the block
	task automatic pulse(input logic [15:0] f, p);
		fire <= f;
		pendSet <= p;
		@(posedge clk_sys);
		fire <= 16'h0;
		pendSet <= 16'h0;
		@(posedge clk_sys);
	endtask : pulse

	task automatic flt(input logic [9:0] f, input logic [3:0] x);
		busFault <= f;
		@(posedge clk_sys);
		busFault <= '0;
		rd(`IMF_ADDR_FAULT, {30'h0, x});
	endtask : flt

	always @(posedge clk_sys) begin
		if (s_axi_bvalid && s_axi_bready) begin
			e = expQ.pop_front();
			`CHK(s_axi_bresp, e[33:32])
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e = expQ.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, e)
		end
	end

	// a hang ends the run as a failure
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			errorCnt++;
			completeRun();
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		rd(`IMF_ADDR_MISS, 34'h0);
		rd(`IMF_ADDR_FAULT, 34'h0);
		rd(32'h4000a82c, {2'h2, 32'h0});
		wr(32'h4000a82c, seed, 2'h2);
		repeat (4) begin
			seed = xs(seed);
			wr(`IMF_ADDR_MISS, seed, 2'h0);
			rd(`IMF_ADDR_MISS, {2'h0, seed & `IMF_MISS_MASK});
			wr(`IMF_ADDR_FAULT, seed, 2'h0);
			rd(`IMF_ADDR_FAULT, {2'h0, seed & `IMF_FAULT_MASK});
		end
		wr(`IMF_ADDR_MISS, 32'h0, 2'h0);
		wr(`IMF_ADDR_ISTAT, 32'h3, 2'h0);
		wr(`IMF_ADDR_IMASK, 32'h1, 2'h0);
		pulse(16'h0800, 16'h0);
		rd(`IMF_ADDR_MISS, 34'h0);
		`CHK(irqOut, 1'h0)
		pulse(16'h0800, 16'h0);
		rd(`IMF_ADDR_MISS, 34'h800);
		`CHK(irqOut, 1'h1)
		pulse(16'h0, 16'hffff);
		pulse(16'hffff, 16'h0);
		rd(`IMF_ADDR_MISS, 34'hfffc);
		wr(`IMF_ADDR_ISTAT, 32'h1, 2'h0);
		`CHK(irqOut, 1'h0)
		rd(`IMF_ADDR_MISS, 34'hfffc);
		// only the strobed byte may change
		s_axi_wstrb <= 4'h2;
		wr(`IMF_ADDR_MISS, 32'h0, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(`IMF_ADDR_MISS, 34'hfc);
		for (int i = 0; i < 8; i++) begin
			wr(`IMF_ADDR_FAULT, 32'h0, 2'h0);
			flt(fTab[i], fExp[i]);
		end
		flt(10'h30e, 4'h7);
		flt(10'h210, 4'hf);
		rd(`IMF_ADDR_ISTAT, 34'h2);
		`CHK(irqOut, 1'h0)
		wr(`IMF_ADDR_IMASK, 32'h3, 2'h0);
		`CHK(irqOut, 1'h1)
		wr(`IMF_ADDR_ISTAT, 32'h2, 2'h0);
		`CHK(irqOut, 1'h0)
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		rd(`IMF_ADDR_FAULT, 34'h0);
		completeRun();
	end
endmodule : imf_tb_top
